// ### core/podl_defs.svh
//----------------------------------------------------------------------
// strap loader constants
//----------------------------------------------------------------------
`ifndef PODL_DEFS_SVH
`define PODL_DEFS_SVH

// timing
`define PODL_CLK_PERIOD_NS 20
`define PODL_POR_PULSE_NS 75
`define PODL_POR_CYCLES \
    ((`PODL_POR_PULSE_NS + `PODL_CLK_PERIOD_NS - 1) / `PODL_CLK_PERIOD_NS)

// widths and reset values
`define PODL_FTW_W 48
`define PODL_ROM_W 16
`define PODL_PLL_MULT_DEFAULT 8'h28
`define PODL_PLL_MULT_RESET 8'h00

// tuning words; f = word / 65536 times the sample clock
`define PODL_ROM_0 16'h0000
`define PODL_ROM_1 16'h09f4
`define PODL_ROM_2 16'h0d45
`define PODL_ROM_3 16'h0fba
`define PODL_ROM_4 16'h13e8
`define PODL_ROM_5 16'h1797
`define PODL_ROM_6 16'h1f75
`define PODL_ROM_7 16'h27d0

// register byte offsets
`define PODL_OFS_FTW_LO 8'h00
`define PODL_OFS_FTW_HI 8'h04
`define PODL_OFS_STATUS 8'h08
`define PODL_OFS_PLL_MULT 8'h0c
`define PODL_OFS_PIN_DRV 8'h10

// status register fields
`define PODL_STAT_CLK_BIT 4
`define PODL_STAT_RST_BIT 5

`endif

// ### core/podl_pkg.sv
//----------------------------------------------------------------------
// strap loader types
//----------------------------------------------------------------------
package podl_pkg;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } podl_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } podl_ahb_rsp_s;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } podl_state_e;

endpackage : podl_pkg

// ### core/podl_strap_rom.sv
`timescale 1ns/1ps
`include "podl_defs.svh"

module podl_strap_rom
(
    input wire logic [2:0] idx,
    output logic [`PODL_ROM_W-1:0] word
);

    //------------------------------------------------------------------
    // default tuning word table
    //------------------------------------------------------------------
    // constant table, no storage needed
    always_comb
    begin
        unique case (idx)
            3'd0: word = `PODL_ROM_0;
            3'd1: word = `PODL_ROM_1;
            3'd2: word = `PODL_ROM_2;
            3'd3: word = `PODL_ROM_3;
            3'd4: word = `PODL_ROM_4;
            3'd5: word = `PODL_ROM_5;
            3'd6: word = `PODL_ROM_6;
            3'd7: word = `PODL_ROM_7;
        endcase
    end

endmodule : podl_strap_rom

// ### core/podl_por_pulse.sv
`timescale 1ns/1ps
`include "podl_defs.svh"

module podl_por_pulse
#(
    parameter int unsigned CYCLES = `PODL_POR_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic supply_hi_good,
    input wire logic supply_lo_good,
    output logic pulse_r
);

    //------------------------------------------------------------------
    // one-shot power-up pulse
    //------------------------------------------------------------------
    logic [7:0] cnt_r;
    logic fired_r;
    wire start = supply_hi_good & supply_lo_good & ~fired_r;
    wire cnt_done = (cnt_r == 8'h00);

    // fires once per power-up; a supply dip later does not refire
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_r <= 8'h00;
            fired_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else if (start)
        begin
            fired_r <= 1'b1;
            pulse_r <= 1'b1;
            cnt_r <= 8'(CYCLES - 1);
        end
        else if (pulse_r)
        begin
            pulse_r <= ~cnt_done;
            cnt_r <= cnt_r - 8'h01;
        end
    end

    a_por_length: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(pulse_r) |-> pulse_r[*4] ##1 !pulse_r)
        else $error("power-up pulse length wrong");

    a_por_supplies: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(pulse_r) |-> $past(supply_hi_good && supply_lo_good))
        else $error("pulse began without both supplies");

    a_por_once: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $past(fired_r) |-> !$rose(pulse_r))
        else $error("power-up pulse fired twice");

endmodule : podl_por_pulse

// ### core/podl_top.sv
`timescale 1ns/1ps
`include "podl_defs.svh"

module podl_top
#(
    parameter int unsigned FTW_W = `PODL_FTW_W,
    parameter int unsigned POR_CYCLES = `PODL_POR_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic supply_hi_good,
    input wire logic supply_lo_good,
    input wire logic ext_reset_n,
    // bit0..2 strap_pin_bit0..2, bit3 strap_clock_source_select
    input wire logic [3:0] strap_pins_in,
    output logic [3:0] strap_pins_out_r,
    output logic [3:0] strap_pins_oe_r,
    input podl_pkg::podl_ahb_req_s ahb_req,
    output podl_pkg::podl_ahb_rsp_s ahb_rsp_r,
    output logic [FTW_W-1:0] primary_tuning_word_reg_r,
    output logic clk_src_direct_r,
    output logic [7:0] pll_mult_r,
    output logic reset_active_r
);
    import podl_pkg::*;

    //------------------------------------------------------------------
    // declarations
    //------------------------------------------------------------------
    localparam int unsigned LOW_W = FTW_W - `PODL_ROM_W;

    podl_state_e state_r;
    podl_state_e state_nxt;
    logic [3:0] strap_r;
    logic [3:0] pin_drv_r;
    logic por_pulse;
    logic [`PODL_ROM_W-1:0] rom_word;
    logic dp_wr_r;
    logic [7:0] dp_addr_r;

    //------------------------------------------------------------------
    // reset sources
    //------------------------------------------------------------------
    podl_por_pulse #(
        .CYCLES(POR_CYCLES)
    ) i_podl_por_pulse (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .supply_hi_good(supply_hi_good),
        .supply_lo_good(supply_lo_good),
        .pulse_r(por_pulse)
    );

    // pin reset only counts once the device has powered up
    wire ext_rst = ~ext_reset_n & ~state_r[0];
    wire rst_nxt = por_pulse | ext_rst;
    // falling edge of the internal reset pulse
    wire capture = reset_active_r & ~rst_nxt;

    //------------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------------
    // wait for power, hold while reset, run afterwards
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_WAIT:
                if (por_pulse)
                    state_nxt = ST_HOLD;
            ST_HOLD:
                if (!rst_nxt)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (rst_nxt)
                    state_nxt = ST_HOLD;
            default:
                state_nxt = ST_WAIT;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            state_r <= ST_WAIT;
        else
            state_r <= state_nxt;
    end

    // reset flag, visible to the rest of the chip
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            reset_active_r <= 1'b0;
        else
            reset_active_r <= rst_nxt;
    end

    //------------------------------------------------------------------
    // status pins
    //------------------------------------------------------------------
    // enable drops on the same edge that reset rises; one clock
    // is the closest a synchronous design gets to instant release
    wire pins_drive = ~rst_nxt & state_nxt[2];

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            strap_pins_oe_r <= 4'h0;
        else
            strap_pins_oe_r <= {4{pins_drive}};
    end

    // normal output function: software driven status levels
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            strap_pins_out_r <= 4'h0;
        else
            strap_pins_out_r <= pin_drv_r;
    end

    //------------------------------------------------------------------
    // strap capture
    //------------------------------------------------------------------
    podl_strap_rom i_podl_strap_rom (
        .idx(strap_pins_in[2:0]),
        .word(rom_word)
    );

    // pins are undriven by us at this edge, so the board sets them
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            strap_r <= 4'h0;
        else if (capture)
            strap_r <= strap_pins_in;
    end

    // clock source follows the fourth bit
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            clk_src_direct_r <= 1'b0;
        else if (capture)
            clk_src_direct_r <= strap_pins_in[3];
    end

    //------------------------------------------------------------------
    // register bus, address phase
    //------------------------------------------------------------------
    wire ap_valid = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    wire [7:0] ap_addr = ahb_req.haddr[7:0];
    wire ap_hit_lo = (ap_addr == `PODL_OFS_FTW_LO);
    wire ap_hit_hi = (ap_addr == `PODL_OFS_FTW_HI);
    wire ap_hit_st = (ap_addr == `PODL_OFS_STATUS);
    wire ap_hit_pm = (ap_addr == `PODL_OFS_PLL_MULT);
    wire ap_hit_pd = (ap_addr == `PODL_OFS_PIN_DRV);

    // status word: strap bits, clock source, reset flag
    wire [31:0] status_word = {26'h000_0000, reset_active_r,
        clk_src_direct_r, strap_r};

    // read data chosen at address phase, stands in the data phase
    wire [31:0] rd_word =
        ap_hit_lo ? primary_tuning_word_reg_r[31:0] :
        ap_hit_hi ? {16'h0000, primary_tuning_word_reg_r[FTW_W-1:32]} :
        ap_hit_st ? status_word :
        ap_hit_pm ? {24'h00_0000, pll_mult_r} :
        ap_hit_pd ? {28'h000_0000, pin_drv_r} :
        32'h0000_0000;

    // latch the write address for the data phase
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end
        else
        begin
            dp_wr_r <= ap_valid & ahb_req.hwrite;
            dp_addr_r <= ap_addr;
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ahb_rsp_r.hrdata <= 32'h0000_0000;
            ahb_rsp_r.hreadyout <= 1'b1;
            ahb_rsp_r.hresp <= 1'b0;
        end
        else
        begin
            ahb_rsp_r.hrdata <= (ap_valid & ~ahb_req.hwrite) ?
                rd_word : 32'h0000_0000;
            ahb_rsp_r.hreadyout <= 1'b1;
            ahb_rsp_r.hresp <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // register bus, data phase writes
    //------------------------------------------------------------------
    // writes are dropped while the device sits in reset
    wire wr_ok = dp_wr_r & state_r[2] & ~rst_nxt;
    wire wr_lo = wr_ok & (dp_addr_r == `PODL_OFS_FTW_LO);
    wire wr_hi = wr_ok & (dp_addr_r == `PODL_OFS_FTW_HI);
    wire wr_pm = wr_ok & (dp_addr_r == `PODL_OFS_PLL_MULT);
    wire wr_pd = wr_ok & (dp_addr_r == `PODL_OFS_PIN_DRV);

    // strap load beats software and needs no update strobe
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            primary_tuning_word_reg_r <= '0;
        else if (capture)
            primary_tuning_word_reg_r <=
                {rom_word, {LOW_W{1'b0}}};
        else
        begin
            if (wr_lo)
                primary_tuning_word_reg_r[31:0] <= ahb_req.hwdata;
            if (wr_hi)
                primary_tuning_word_reg_r[FTW_W-1:32] <=
                    ahb_req.hwdata[FTW_W-33:0];
        end
    end

    // multiplier defaults only when the PLL path is strapped
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            pll_mult_r <= `PODL_PLL_MULT_RESET;
        else if (capture & ~strap_pins_in[3])
            pll_mult_r <= `PODL_PLL_MULT_DEFAULT;
        else if (wr_pm)
            pll_mult_r <= ahb_req.hwdata[7:0];
    end

    // levels that the pins show in normal operation
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            pin_drv_r <= 4'h0;
        else if (wr_pd)
            pin_drv_r <= ahb_req.hwdata[3:0];
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    a_pins_release: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(reset_active_r) |-> strap_pins_oe_r == 4'h0)
        else $error("pins still driven as reset rose");

    a_pins_held: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        reset_active_r |-> strap_pins_oe_r == 4'h0)
        else $error("pins driven during reset");

    a_strap_latch: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        capture |=> strap_r == $past(strap_pins_in))
        else $error("strap bits not latched at reset end");

    a_ext_reset: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (state_r == ST_RUN && !ext_reset_n) |=>
            reset_active_r && strap_pins_oe_r == 4'h0)
        else $error("reset pin did not start strap sequence");

    a_ftw_load: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        capture |=> primary_tuning_word_reg_r ==
            {$past(rom_word), {LOW_W{1'b0}}})
        else $error("tuning word not loaded from table");

    a_ftw_index: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (capture && strap_pins_in[2:0] == 3'd7) |=>
            primary_tuning_word_reg_r[FTW_W-1:LOW_W] == `PODL_ROM_7)
        else $error("table index wrong");

    a_clk_source: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        capture |=> clk_src_direct_r == $past(strap_pins_in[3]))
        else $error("clock source not from fourth strap");

    a_pll_default: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (capture && !strap_pins_in[3]) |=>
            pll_mult_r == `PODL_PLL_MULT_DEFAULT)
        else $error("multiplier not defaulted in PLL mode");

    a_pins_return: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(reset_active_r) |-> strap_pins_oe_r == 4'hf)
        else $error("pins not driven after reset");

    a_pins_driven: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        state_r == ST_RUN |-> strap_pins_oe_r == 4'hf)
        else $error("pins undriven while running");

    a_pll_keep: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (capture && strap_pins_in[3]) |=>
            pll_mult_r == $past(pll_mult_r))
        else $error("multiplier changed in direct mode");

    a_ftw_frozen: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (reset_active_r && !capture) |=>
            $stable(primary_tuning_word_reg_r))
        else $error("tuning word changed during reset");

    a_hrdata_idle: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !(ap_valid && !ahb_req.hwrite) |=>
            ahb_rsp_r.hrdata == 32'h0000_0000)
        else $error("read data outside its data phase");

    a_wait_quiet: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        state_r == ST_WAIT |-> !reset_active_r)
        else $error("reset flag up before power-up pulse");

    a_ext_ignored: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (state_r == ST_WAIT && !por_pulse) |=> !reset_active_r)
        else $error("reset pin acted before power-up");

    a_bus_okay: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ahb_rsp_r.hreadyout && !ahb_rsp_r.hresp)
        else $error("bus response not ready and OKAY");

endmodule : podl_top

// ### test/podl_board.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// board side: strap resistors and the external reset button
// ----------------------------------------------------------------
module podl_board
(
    input wire logic [3:0] strap_pull,
    input wire logic [3:0] pins_out,
    input wire logic [3:0] pins_oe,
    input wire logic rst_press,
    output logic [3:0] pins_in,
    output logic ext_reset_n
);
    // a released pin settles to its resistor, never to the last level
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & strap_pull);
    // the button pulls the reset line low while pressed
    assign ext_reset_n = ~rst_press;
endmodule : podl_board

// ### test/power_on_strap_default_tuning_loader_tb.sv
`timescale 1ns/1ps
module power_on_strap_default_tuning_loader_tb;
    import podl_pkg::*;
    localparam int unsigned POR_N = 4;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hi_good = 1'b0;
    logic lo_good = 1'b0;
    logic rst_press = 1'b0;
    logic [3:0] strap_pull = 4'h5;
    logic ext_reset_n;
    logic [3:0] pins_in;
    logic [3:0] pins_out;
    logic [3:0] pins_oe;
    podl_ahb_req_s req = '0;
    podl_ahb_req_s bus_req;
    podl_ahb_rsp_s rsp;
    logic [47:0] frequency_tuning_word;
    logic clk_dir;
    logic [7:0] pll_mult;
    logic rst_act;
    int failures = 0;
    int n_compared = 0;
    // word = output frequency / 1 GHz * 65536, rounded
    logic [15:0] rom_exp [8] = '{16'h0000, 16'h09f4, 16'h0d45, 16'h0fba,
        16'h13e8, 16'h1797, 16'h1f75, 16'h27d0};

    // ------------------------------------------------------------
    // clock, bus ready loop-back, design and board
    // ------------------------------------------------------------
    always #10 clk_sys = ~clk_sys;
    always_comb
    begin
        bus_req = req;
        bus_req.hready = rsp.hreadyout;
    end
    podl_top #(.POR_CYCLES(POR_N)) i_podl_top (.clk_sys(clk_sys),
        .nrst(nrst), .supply_hi_good(hi_good), .supply_lo_good(lo_good),
        .ext_reset_n(ext_reset_n), .strap_pins_in(pins_in),
        .strap_pins_out_r(pins_out), .strap_pins_oe_r(pins_oe),
        .ahb_req(bus_req), .ahb_rsp_r(rsp),
        .primary_tuning_word_reg_r(frequency_tuning_word), .clk_src_direct_r(clk_dir),
        .pll_mult_r(pll_mult), .reset_active_r(rst_act));
    podl_board i_podl_board (.strap_pull(strap_pull), .pins_out(pins_out),
        .pins_oe(pins_oe), .rst_press(rst_press), .pins_in(pins_in),
        .ext_reset_n(ext_reset_n));

    // ------------------------------------------------------------
    // compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // ready and read data are sampled mid-cycle, so no edge race
    task automatic bus_xfer(input logic wr, input logic [31:0] addr,
        input logic [31:0] wdata, output logic [31:0] rdata);
        logic rdy;
        @(posedge clk_sys);
        req.hsel <= 1'b1;
        req.haddr <= addr;
        req.htrans <= 2'b10;
        req.hwrite <= wr;
        req.hsize <= 3'b010;
        rdy = 1'b0;
        while (rdy !== 1'b1)
        begin
            @(negedge clk_sys);
            rdy = rsp.hreadyout;
            @(posedge clk_sys);
        end
        req.hsel <= 1'b0;
        req.htrans <= 2'b00;
        req.hwdata <= wdata;
        rdy = 1'b0;
        while (rdy !== 1'b1)
        begin
            @(negedge clk_sys);
            rdy = rsp.hreadyout;
            rdata = rsp.hrdata;
            @(posedge clk_sys);
        end
    endtask : bus_xfer

    task automatic bus_wr(input logic [31:0] addr, input logic [31:0] d);
        logic [31:0] unused;
        bus_xfer(1'b1, addr, d, unused);
    endtask : bus_wr

    task automatic bus_rd(input string what, input logic [31:0] addr,
        input logic [31:0] exp);
        logic [31:0] rd;
        bus_xfer(1'b0, addr, 32'h0, rd);
        check(what, rd, exp);
    endtask : bus_rd

    // ------------------------------------------------------------
    // pulse tracking and capture checks
    // ------------------------------------------------------------
    task automatic no_pulse(input int n);
        repeat (n)
        begin
            @(negedge clk_sys);
            check("no pulse", rst_act, 1'b0);
        end
    endtask : no_pulse

    // bounded wait: a pulse that never comes shows as length zero
    task automatic run_pulse(output int len);
        int t;
        len = 0;
        for (t = 0; t < 50 && rst_act !== 1'b1; t++)
            @(negedge clk_sys);
        while (rst_act === 1'b1 && len < 50)
        begin
            check("pins released", pins_oe, 4'h0);
            len++;
            @(negedge clk_sys);
        end
    endtask : run_pulse

    task automatic chk_capture(input logic [3:0] s, input logic [7:0] m);
        logic [47:0] ftw_exp;
        ftw_exp = {rom_exp[s[2:0]], 32'h0000_0000};
        check("ftw", frequency_tuning_word, ftw_exp);
        check("clk src", clk_dir, s[3]);
        check("pll mult", pll_mult, m);
        check("pins driven", pins_oe, 4'hf);
        bus_rd("status", 32'h0000_0008, {27'h0, s[3], s});
        bus_rd("ftw hi", 32'h0000_0004, {16'h0, rom_exp[s[2:0]]});
    endtask : chk_capture

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        int len;
        logic [7:0] prev;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("reset pulse idle", rst_act, 1'b0);
        check("reset ready", rsp.hreadyout, 1'b1);
        @(posedge clk_sys);
        nrst <= 1'b1;
        $display("test reset done");
        // one supply at a time must not start the pulse
        hi_good <= 1'b1;
        no_pulse(5);
        @(posedge clk_sys);
        hi_good <= 1'b0;
        lo_good <= 1'b1;
        no_pulse(5);
        @(posedge clk_sys);
        hi_good <= 1'b1;
        run_pulse(len);
        check("pulse length", len, POR_N);
        chk_capture(4'h5, 8'h28);
        $display("test power-up done");
        // pins are driven opposite to the straps before each reset,
        // so a pin left driven would be captured wrongly
        for (int i = 0; i < 16; i++)
        begin
            prev = 8'h10 + 8'(i);
            bus_wr(32'h0000_000c, {24'h0, prev});
            bus_wr(32'h0000_0010, {28'h0, ~4'(i)});
            repeat (2) @(negedge clk_sys);
            check("pin wire", pins_in, {~4'(i)});
            @(posedge clk_sys);
            strap_pull <= 4'(i);
            rst_press <= 1'b1;
            @(posedge clk_sys);
            rst_press <= 1'b0;
            run_pulse(len);
            chk_capture(4'(i), i[3] ? prev : 8'h28);
        end
        $display("test external reset done");
        // live tuning word writes, read-only and unmapped places
        bus_wr(32'h0000_0000, 32'h1234_5678);
        bus_wr(32'h0000_0004, 32'h0000_abcd);
        @(negedge clk_sys);
        check("ftw live", frequency_tuning_word, 48'habcd_1234_5678);
        bus_wr(32'h0000_0008, 32'hffff_ffff);
        bus_rd("status ro", 32'h0000_0008, 32'h0000_001f);
        bus_rd("unmapped", 32'h0000_0014, 32'h0000_0000);
        $display("test register bus done");
        print_verdict();
    end

    // the whole run needs well under two thousand cycles
    initial
    begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule : power_on_strap_default_tuning_loader_tb
